// ---- src/bsc_pkg.sv ----
// Purpose: Shared constants for the bridge switching and protection block
// Assumes: 100 MHz system clock
// Notes:   Times in their own unit, cycle counts derived from them
package bsc_pkg;
  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam int CLK_MHZ           = 100;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int WDOG_NS           = 32000;
  localparam int OSC_KHZ           = 450;
  localparam int BLANK_US          = 2400;
  localparam int RETRY_US          = 76000;
  localparam int DEAD_NS           = 30;
  localparam int WDOG_CYC          = (WDOG_NS * CLK_MHZ) / 1000;
  // Half period of the switching signal, rounded down
  localparam int OSC_HALF_CYC      = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
  localparam int BLANK_CYC         = BLANK_US * CLK_MHZ;
  localparam int RETRY_CYC         = RETRY_US * CLK_MHZ;
  // Least time, rounded up
  localparam int DEAD_CYC          = (DEAD_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  // Order {uv, ot, oc, en_n, clk}: disables start set to keep the bridge off,
  // fault flags start clear so the fault pin does not blip after reset
  localparam logic [4:0] SYNC_RST  = 5'h12;
  // ----------------------------------------
  // Protection states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PROT_RUN   = 2'b00,
    PROT_BLANK = 2'b01,
    PROT_OFF   = 2'b10
  } prot_state_type;
endpackage

// ---- src/bsc_drive_if.sv ----
// Purpose: Carries the switching phase and enable to the bridge output stage
// Assumes: Single clock domain
// Notes:   Phase is the divided switching signal
`timescale 1ns/1ps
interface bsc_drive_if;
  logic phase;
  logic enable;
  modport src  (output phase, output enable);
  modport sink (input  phase, input  enable);
endinterface

// ---- src/bsc_deadtime.sv ----
// Purpose: Break-before-make bridge leg driver with dead time
// Assumes: Phase and enable are synchronous to clk_in
// Notes:   Outputs are tri-stated while disabled
`timescale 1ns/1ps
module bsc_deadtime #(
  parameter int DEAD_CYC = bsc_pkg::DEAD_CYC
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  bsc_drive_if.sink drv,
  output logic      leg_a_out,
  output logic      leg_b_out,
  output logic      leg_oe_out
);
  localparam int CW = $clog2(DEAD_CYC + 1) + 1;
  logic [CW-1:0] dead_ff;
  logic [CW-1:0] nxt_dead;
  logic          last_ff;
  logic          nxt_last;
  logic          nxt_a;
  logic          nxt_b;
  logic          nxt_oe;
  logic          leg_a_ff;
  logic          leg_b_ff;
  logic          leg_oe_ff;

  always_comb begin
    nxt_dead = dead_ff;
    nxt_last = last_ff;
    nxt_a    = leg_a_ff;
    nxt_b    = leg_b_ff;
    nxt_oe   = drv.enable;
    if (!drv.enable) begin
      nxt_a    = 1'b0;
      nxt_b    = 1'b0;
      nxt_dead = CW'(DEAD_CYC);
      nxt_last = drv.phase;
    end else if (drv.phase != last_ff) begin
      // Both legs off first, so the bridge never shoots through
      nxt_a    = 1'b0;
      nxt_b    = 1'b0;
      nxt_dead = CW'(DEAD_CYC);
      nxt_last = drv.phase;
    end else if (dead_ff != '0) begin
      nxt_dead = dead_ff - CW'(1);
    end else begin
      nxt_a = last_ff;
      nxt_b = ~last_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dead_ff   <= '0;
      last_ff   <= 1'b0;
      leg_a_ff  <= 1'b0;
      leg_b_ff  <= 1'b0;
      leg_oe_ff <= 1'b0;
    end else if (clk_en_in) begin
      dead_ff   <= nxt_dead;
      last_ff   <= nxt_last;
      leg_a_ff  <= nxt_a;
      leg_b_ff  <= nxt_b;
      leg_oe_ff <= nxt_oe;
    end
  end

  assign leg_a_out  = leg_a_ff;
  assign leg_b_out  = leg_b_ff;
  assign leg_oe_out = leg_oe_ff;
endmodule

// ---- src/bsc_top.sv ----
// Purpose: Clock selection, divide-by-two, watchdog and protection for an H-bridge
// Assumes: Pin inputs are asynchronous and synchronised here
// Notes:   Analog sensing arrives as flags; dead time is a cycle count
`timescale 1ns/1ps
// Contract
// - Internal oscillator after 32 us low clock
// - Internal oscillator switches bridge at 450 kHz
// - External clock: switch on rising edges only
// - Divide external clock by two, 50% duty
// - Sync clock follows internal or external rate
// - Watchdog falls back after 32 us stall
// - Overcurrent beyond 2.4 ms disables and faults
// - Retry after 76 ms, release fault
// - Persistent overcurrent repeats blank and retry
// - Fault on overcurrent or thermal shutdown
// - Thermal fault held steady, no retry
// - Overtemperature disables bridge, sync clock runs
// - Temperature clear re-enables, releases fault
// - Enable high tri-states bridge, clock runs
// - Undervoltage tri-states bridge
// - Dead time between leg changes
// - No fault: fault output released
module bsc_top #(
  parameter int WDOG_CYC     = bsc_pkg::WDOG_CYC,
  parameter int OSC_HALF_CYC = bsc_pkg::OSC_HALF_CYC,
  parameter int BLANK_CYC    = bsc_pkg::BLANK_CYC,
  parameter int RETRY_CYC    = bsc_pkg::RETRY_CYC,
  parameter int DEAD_CYC     = bsc_pkg::DEAD_CYC
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  input  wire logic ext_clock_input_in,
  input  wire logic enable_n_in,
  input  wire logic overcurrent_in,
  input  wire logic overtemp_in,
  input  wire logic undervoltage_in,
  output logic      bridge_out_a_out,
  output logic      bridge_out_a_oe_out,
  output logic      bridge_out_b_out,
  output logic      bridge_out_b_oe_out,
  output logic      sync_clock_output_out,
  output logic      sync_clock_output_oe_out,
  output logic      fault_out,
  output logic      fault_oe_out
);
  localparam int WW = $clog2(WDOG_CYC + 1);
  localparam int OW = $clog2(OSC_HALF_CYC + 1);
  localparam int PW = $clog2((BLANK_CYC > RETRY_CYC ? BLANK_CYC : RETRY_CYC) + 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] nxt_sync1;
  logic       clk_s;
  logic       en_n_s;
  logic       oc_s;
  logic       ot_s;
  logic       uv_s;

  always_comb begin
    nxt_sync1 = {undervoltage_in, overtemp_in, overcurrent_in, enable_n_in, ext_clock_input_in};
  end
  assign {uv_s, ot_s, oc_s, en_n_s, clk_s} = sync2_ff;

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  logic          clk_d_ff;
  logic          ext_sel_ff;
  logic [WW-1:0] wdog_ff;
  logic [OW-1:0] osc_ff;
  logic          osc_clk_ff;
  logic          phase_ff;
  logic          nxt_clk_d;
  logic          nxt_ext_sel;
  logic [WW-1:0] nxt_wdog;
  logic [OW-1:0] nxt_osc;
  logic          nxt_osc_clk;
  logic          nxt_phase;
  logic          ext_rise;
  logic          sync_clk_ff;
  logic          nxt_sync_clk;

  assign ext_rise = clk_s & ~clk_d_ff;

  always_comb begin
    nxt_clk_d   = clk_s;
    nxt_ext_sel = ext_sel_ff;
    nxt_wdog    = wdog_ff;
    nxt_osc     = osc_ff;
    nxt_osc_clk = osc_clk_ff;
    nxt_phase   = phase_ff;
    // Watchdog restarts on every level change of the external clock
    if (clk_s != clk_d_ff) begin
      nxt_wdog = '0;
    end else if (wdog_ff < WW'(WDOG_CYC)) begin
      nxt_wdog = wdog_ff + WW'(1);
    end
    if (ext_rise) begin
      // Returning source waits for a rising edge, so no short half period
      nxt_ext_sel = 1'b1;
      nxt_phase   = ~phase_ff;
    end else if (nxt_wdog == WW'(WDOG_CYC)) begin
      nxt_ext_sel = 1'b0;
    end
    // Internal oscillator ticks at twice the switching rate
    if (osc_ff >= OW'(OSC_HALF_CYC - 1)) begin
      nxt_osc     = '0;
      nxt_osc_clk = ~osc_clk_ff;
      if (!ext_sel_ff && !ext_rise) begin
        nxt_phase = ~phase_ff;
      end
    end else begin
      nxt_osc = osc_ff + OW'(1);
    end
    // Sync clock follows the active source rate
    nxt_sync_clk = ext_sel_ff ? clk_s : osc_clk_ff;
  end

  // ----------------------------------------
  // Overcurrent blanking and autoretry
  // ----------------------------------------
  bsc_pkg::prot_state_type prot_ff;
  bsc_pkg::prot_state_type nxt_prot;
  logic [PW-1:0]           ptmr_ff;
  logic [PW-1:0]           nxt_ptmr;
  logic                    oc_off;
  logic                    run_en;
  logic                    fault_ff;
  logic                    nxt_fault;

  always_comb begin
    nxt_prot = prot_ff;
    nxt_ptmr = ptmr_ff;
    unique case (prot_ff)
      bsc_pkg::PROT_RUN: begin
        nxt_ptmr = '0;
        if (oc_s) begin
          nxt_prot = bsc_pkg::PROT_BLANK;
        end
      end
      bsc_pkg::PROT_BLANK: begin
        if (!oc_s) begin
          nxt_prot = bsc_pkg::PROT_RUN;
          nxt_ptmr = '0;
        end else if (ptmr_ff >= PW'(BLANK_CYC - 1)) begin
          nxt_prot = bsc_pkg::PROT_OFF;
          nxt_ptmr = '0;
        end else begin
          nxt_ptmr = ptmr_ff + PW'(1);
        end
      end
      bsc_pkg::PROT_OFF: begin
        if (ptmr_ff >= PW'(RETRY_CYC - 1)) begin
          nxt_prot = bsc_pkg::PROT_RUN;
          nxt_ptmr = '0;
        end else begin
          nxt_ptmr = ptmr_ff + PW'(1);
        end
      end
      default: begin
        nxt_prot = bsc_pkg::PROT_RUN;
        nxt_ptmr = '0;
      end
    endcase
    oc_off    = (prot_ff == bsc_pkg::PROT_OFF);
    // Thermal fault is a plain level, so it never toggles
    nxt_fault = oc_off | ot_s;
    run_en    = ~oc_off & ~ot_s & ~en_n_s & ~uv_s;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync1_ff    <= bsc_pkg::SYNC_RST;
      sync2_ff    <= bsc_pkg::SYNC_RST;
      clk_d_ff    <= 1'b0;
      ext_sel_ff  <= 1'b0;
      wdog_ff     <= '0;
      osc_ff      <= '0;
      osc_clk_ff  <= 1'b0;
      phase_ff    <= 1'b0;
      sync_clk_ff <= 1'b0;
      prot_ff     <= bsc_pkg::PROT_RUN;
      ptmr_ff     <= '0;
      fault_ff    <= 1'b0;
    end else if (clk_en_in) begin
      sync1_ff    <= nxt_sync1;
      sync2_ff    <= sync1_ff;
      clk_d_ff    <= nxt_clk_d;
      ext_sel_ff  <= nxt_ext_sel;
      wdog_ff     <= nxt_wdog;
      osc_ff      <= nxt_osc;
      osc_clk_ff  <= nxt_osc_clk;
      phase_ff    <= nxt_phase;
      sync_clk_ff <= nxt_sync_clk;
      prot_ff     <= nxt_prot;
      ptmr_ff     <= nxt_ptmr;
      fault_ff    <= nxt_fault;
    end
  end

  // ----------------------------------------
  // Bridge stage and open-drain outputs
  // ----------------------------------------
  bsc_drive_if drv ();
  logic leg_a;
  logic leg_b;
  logic leg_oe;

  assign drv.phase  = phase_ff;
  assign drv.enable = run_en;

  bsc_deadtime #(
    .DEAD_CYC (DEAD_CYC)
  ) u_dead (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .clk_en_in  (clk_en_in),
    .drv        (drv),
    .leg_a_out  (leg_a),
    .leg_b_out  (leg_b),
    .leg_oe_out (leg_oe)
  );

  assign bridge_out_a_out         = leg_a;
  assign bridge_out_b_out         = leg_b;
  assign bridge_out_a_oe_out      = leg_oe;
  assign bridge_out_b_oe_out      = leg_oe;
  // Open drain: pull low to signal
  assign sync_clock_output_out    = 1'b0;
  assign sync_clock_output_oe_out = ~sync_clk_ff;
  assign fault_out                = 1'b0;
  assign fault_oe_out             = fault_ff;
endmodule

// ---- tb/bsc_asserts.sv ----
// Purpose: Concurrent checks on the bridge switching block ports
// Assumes: Shortened timing parameters on the bound instance
// Notes:   Attached to every bsc_top by bind
`timescale 1ns/1ps
module bsc_asserts (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic overcurrent_in,
  input wire logic overtemp_in,
  input wire logic enable_n_in,
  input wire logic undervoltage_in,
  input wire logic bridge_out_a_out,
  input wire logic bridge_out_a_oe_out,
  input wire logic bridge_out_b_out,
  input wire logic bridge_out_b_oe_out,
  input wire logic sync_clock_output_oe_out,
  input wire logic fault_oe_out,
  input wire logic sync_clock_output_out,
  input wire logic fault_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------
  // Sync clock stall counter
  // ----------------------------------------
  logic [7:0] still_ff;
  logic       prev_ff;
  always_ff @(posedge clk_in) begin
    prev_ff <= sync_clock_output_oe_out;
    if (reset_in || sync_clock_output_oe_out != prev_ff) still_ff <= 8'h00;
    else if (still_ff != 8'hFF) still_ff <= still_ff + 8'h01;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  legs_exclusive_a: assert property (!(bridge_out_a_out && bridge_out_a_oe_out &&
    bridge_out_b_out && bridge_out_b_oe_out)) else $error("both legs driven high");
  dead_gap_a: assert property ($fell(bridge_out_a_out) |-> !bridge_out_b_out [*3])
    else $error("dead time too short");
  thermal_fault_a: assert property (overtemp_in [*4] |=> fault_oe_out)
    else $error("no fault during overtemperature");
  shutdown_hiz_a: assert property (fault_oe_out && $past(fault_oe_out) |->
    !bridge_out_a_oe_out && !bridge_out_b_oe_out) else $error("bridge driven in shutdown");
  disable_hiz_a: assert property ((enable_n_in || undervoltage_in) [*4] |=>
    !bridge_out_a_oe_out && !bridge_out_b_oe_out) else $error("bridge driven while disabled");
  fault_cause_a: assert property ($rose(fault_oe_out) && !$past(reset_in, 6) |->
    $past(overtemp_in, 3) || $past(overcurrent_in, 3)) else $error("fault without cause");
  retry_hold_a: assert property ($rose(fault_oe_out) && !overtemp_in |=> fault_oe_out [*8])
    else $error("overcurrent fault released early");
  sync_runs_a: assert property (still_ff < 8'h28)
    else $error("sync clock stalled");
  freeze_hold_a: assert property (!clk_en_in |=> $stable(fault_oe_out) && // Clock enable freeze
    $stable(sync_clock_output_oe_out) && $stable(bridge_out_a_oe_out)) else $error("state moved while frozen");
  drain_low_a: assert property (!sync_clock_output_out && !fault_out)
    else $error("open-drain pin driven high");
endmodule
bind bsc_top bsc_asserts chk (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .overcurrent_in(overcurrent_in),
  .overtemp_in(overtemp_in), .enable_n_in(enable_n_in), .undervoltage_in(undervoltage_in),
  .bridge_out_a_out(bridge_out_a_out), .bridge_out_a_oe_out(bridge_out_a_oe_out),
  .bridge_out_b_out(bridge_out_b_out), .bridge_out_b_oe_out(bridge_out_b_oe_out),
  .sync_clock_output_oe_out(sync_clock_output_oe_out), .fault_oe_out(fault_oe_out),
  .sync_clock_output_out(sync_clock_output_out), .fault_out(fault_out));

// ---- tb/bsc_ext_clock_src.sv ----
// Purpose: External clock source feeding the clock pin
// Assumes: Half period given in 10 ns steps
// Notes:   Stands low while stopped
`timescale 1ns/1ps
module bsc_ext_clock_src (
  input  wire logic       run_in,
  input  wire logic [7:0] half_cyc_in,
  output logic            ext_clock_out
);
  initial ext_clock_out = 1'b0;
  always begin
    if (run_in) begin
      #(half_cyc_in * 10) ext_clock_out = ~ext_clock_out;
    end else begin
      ext_clock_out = 1'b0;
      @(posedge run_in);
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the bridge switching block
// Assumes: Shortened timing parameters
// Notes:   Periods and fault edges checked against queued notes
`timescale 1ns/1ps
module testbench;
  // Half period must exceed the dead time by two cycles or a leg never turns on
  localparam int HALF  = 8;
  localparam int BLANK = 50;
  localparam int RETRY = 100;
  logic       clk_in   = 1'b0;
  logic       reset_in = 1'b1;
  logic       clk_en   = 1'b1;
  logic       ext_run  = 1'b0;
  logic [7:0] ext_h    = 8'h06;
  logic       en_n     = 1'b0;
  logic       oc       = 1'b0;
  logic       ot       = 1'b0;
  logic       uv       = 1'b0;
  logic       mon_on   = 1'b0;
  logic       a_prev   = 1'b0;
  logic       f_prev   = 1'b0;
  wire logic  ext, a, a_oe, b_oe, f_oe;
  int         num_errors = 0;
  int         checks_done = 0;
  int         a_cnt, f_cnt, t_len;
  int         per_q[$];
  int         fl_q[$];
  logic       fv_q[$];
  always #5 clk_in = ~clk_in;
  bsc_ext_clock_src src (.run_in(ext_run), .half_cyc_in(ext_h), .ext_clock_out(ext));
  bsc_top #(.WDOG_CYC(20), .OSC_HALF_CYC(HALF), .BLANK_CYC(BLANK), .RETRY_CYC(RETRY), .DEAD_CYC(3)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en), .ext_clock_input_in(ext),
    .enable_n_in(en_n), .overcurrent_in(oc), .overtemp_in(ot), .undervoltage_in(uv),
    .bridge_out_a_out(a), .bridge_out_a_oe_out(a_oe), .bridge_out_b_out(), .bridge_out_b_oe_out(b_oe),
    .sync_clock_output_out(), .sync_clock_output_oe_out(), .fault_out(), .fault_oe_out(f_oe));
  task automatic cmp_period(int exp, int got);
    checks_done++;
    if (exp != got) begin
      num_errors++;
      $display("unexpected bridge period: expected %0d seen %0d", exp, got);
    end
  endtask
  task automatic cmp_fault(logic exp, logic got, int len, int exp_len);
    checks_done++;
    if (got !== exp || (exp_len > 0 && (len < exp_len - 2 || len > exp_len + 2))) begin
      num_errors++;
      $display("unexpected fault level/length: expected %0b/%0d seen %0b/%0d", exp, exp_len, got, len);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Skip the first rise: the interval before it spans a mode change
  task automatic measure(int p);
    @(posedge a);
    tick(1);
    repeat (3) per_q.push_back(p);
    tick(4 * p);
  endtask
  task automatic note(logic v, int len);
    fv_q.push_back(v);
    fl_q.push_back(len);
  endtask
  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  // Falling edge: outputs launched at the rising edge have settled
  always @(negedge clk_in) begin
    a_cnt++;
    f_cnt++;
    if (a === 1'b1 && a_prev === 1'b0) begin
      if (per_q.size() > 0) cmp_period(per_q.pop_front(), a_cnt);
      a_cnt = 0;
    end
    if (mon_on && f_oe !== f_prev) begin
      if (fv_q.size() > 0) cmp_fault(fv_q.pop_front(), f_oe, f_cnt, fl_q.pop_front());
      else cmp_fault(f_prev, f_oe, 0, 0);
      f_cnt = 0;
    end
    a_prev = a;
    f_prev = f_oe;
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    void'($urandom(32'h309E));
    tick(12);
    reset_in = 1'b0;
    tick(30);
    mon_on = 1'b1;
    measure(2 * HALF);
    for (int i = 0; i < 2; i++) begin
      ext_h = 8'($urandom_range(5, 9));
      ext_run = 1'b1;
      tick(20);
      measure(4 * ext_h);
      ext_run = 1'b0;
      tick(40);
      measure(2 * HALF);
    end
    en_n = 1'b1;
    tick(10);
    // Freeze while the bridge is off, so no timed check spans it
    clk_en = 1'b0;
    tick(8);
    clk_en = 1'b1;
    tick($urandom_range(10, 30));
    en_n = 1'b0;
    uv = 1'b1;
    tick($urandom_range(10, 30));
    uv = 1'b0;
    // Longer than the retry time, so a retry toggle would show
    t_len = $urandom_range(RETRY + 10, RETRY + 60);
    note(1'b1, 0);
    note(1'b0, t_len);
    ot = 1'b1;
    tick(t_len);
    ot = 1'b0;
    tick(20);
    note(1'b1, 0);
    note(1'b0, RETRY);
    note(1'b1, BLANK);
    note(1'b0, RETRY);
    oc = 1'b1;
    while (fv_q.size() > 1) tick(1);
    oc = 1'b0;
    tick(RETRY + 40);
    if (fv_q.size() + per_q.size() != 0) num_errors++;
    give_verdict();
  end
  initial begin
    tick(20000);
    num_errors++;
    give_verdict();
  end
endmodule
